//--- verilog/cfd_core.sv
// CPU core: prefetch, single-cycle execute, data space decode, self-programming.
// Assumes program memory answers combinationally to pm_addr_o, and data memory
// answers combinationally to the registered data request outputs.
// Behaviour
// - Program fetch and data access use separate ports that work independently.
// - Next instruction is fetched while the current one executes.
// - Single-cycle instructions complete one per clock.
// - Two registers are read and combined within one clock.
// - Operations on register pairs, register with constant, and single register.
// - Flags are updated after every arithmetic or logic operation.
// - Four register pairs (0x1A, 0x1C, 0x1E, 0x00) serve as 16-bit data pointers; the pair at 0x1E also points into program.
// - Program and data addresses reach 16MB each without banking.
// - Peripheral registers occupy the lowest 4KB of data space.
// - The lowest 64 I/O locations reachable by I/O and data accesses.
// - I/O 0x0040 to 0x0FFF reachable only by data loads and stores.
// - Data 0x1000 to 0x1FFF is reserved for the mapped nonvolatile data.
// - Internal SRAM starts at data address 0x2000.
// - Instructions come only from program memory, never from data RAM.
// - Self-program store works only when executed from the boot section.
// - Each program section has lock bits blocking writes or reads and writes.
// - Fetch starts at address zero; program counter holds next fetch address.
module cfd_core (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	// Program memory port
	output logic      [22:0] pm_addr_o,
	output logic             pm_rd_o,
	input  wire logic [15:0] pm_data_i,
	// Data memory port
	output logic      [23:0] dm_addr_o,
	output logic             dm_re_o,
	output logic             dm_we_o,
	output logic      [7:0]  dm_wdata_o,
	output logic      [3:0]  dm_region_o,
	output logic             dm_io_direct_o,
	input  wire logic [7:0]  dm_rdata_i,
	// Self-programming port
	output logic             spm_req_o,
	output logic             spm_denied_o,
	output logic      [22:0] spm_addr_o,
	output logic      [15:0] spm_data_o,
	// Section locks
	input  wire logic [1:0]  lock_app_i,
	input  wire logic [1:0]  lock_tbl_i,
	input  wire logic [1:0]  lock_boot_i,
	// Status
	output logic      [2:0]  flags_o
);
	// ****************************************
	// State and storage
	// ****************************************
	typedef enum logic [2:0] {
		ST_EXEC = 3'b001,
		ST_LDW  = 3'b010,
		ST_LPMW = 3'b100
	} cfd_state_e;

	cfd_state_e  state;
	logic [22:0] pc;
	logic [22:0] ir_pc;
	logic [15:0] ir;
	logic        ir_valid;
	logic [7:0]  dext;
	logic [7:0]  pext;
	logic [4:0]  ld_dst;
	logic        lpm_hi;
	logic [1:0]  lpm_lock;
	logic [22:0] rstk [cfd_pkg::RSTK_N];
	logic [1:0]  rsp;

	// ****************************************
	// Decode and execute
	// ****************************************
	logic [3:0]  op;
	logic [3:0]  sub;
	logic [7:0]  kval;
	logic [4:0]  ra_addr;
	logic [4:0]  rb_addr;
	logic [7:0]  ra;
	logic [7:0]  rb;
	logic [15:0] ptr;
	logic [15:0] pair0;
	logic [22:0] rel_tgt;
	logic [22:0] z_word;
	logic        exe;
	logic        rf_we;
	logic [4:0]  rf_waddr;
	logic [7:0]  rf_wdata;
	logic        alu_op;
	logic [8:0]  alu_res;
	logic        take_jump;
	logic [22:0] jump_tgt;
	logic        d_re;
	logic        d_we;
	logic        d_io;
	logic [23:0] d_addr;
	logic [3:0]  d_region;
	logic [7:0]  lpm_byte;

	assign op      = ir[cfd_pkg::OP_HI:cfd_pkg::OP_LO];
	assign sub     = ir[cfd_pkg::SUB_HI:cfd_pkg::SUB_LO];
	assign kval    = ir[cfd_pkg::K_HI:cfd_pkg::K_LO];
	assign exe     = ir_valid && state == ST_EXEC;
	assign rel_tgt = ir_pc + 23'h00_0001
		+ 23'(signed'(ir[cfd_pkg::OFS_HI:cfd_pkg::OFS_LO]));
	assign z_word  = {pext[6:0], ptr};
	assign ra_addr = (op == cfd_pkg::OP_LDI || op == cfd_pkg::OP_SUBI)
		? cfd_pkg::LDI_BASE + {1'b0, ir[cfd_pkg::SUB_HI:cfd_pkg::SUB_LO]}
		: (op == cfd_pkg::OP_OUT) ? ir[cfd_pkg::IRD_HI:cfd_pkg::IRD_LO]
		: ir[cfd_pkg::RD_HI:cfd_pkg::RD_LO];
	assign rb_addr = ir[cfd_pkg::RR_HI:cfd_pkg::RR_LO];

	cfd_regfile u_rf (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.we_i      (rf_we),
		.waddr_i   (rf_waddr),
		.wdata_i   (rf_wdata),
		.ra_addr_i (ra_addr),
		.rb_addr_i (rb_addr),
		.ra_o      (ra),
		.rb_o      (rb),
		.ptr_lo_i  (op == cfd_pkg::OP_MISC ? 5'h1E : 5'h1A + {2'h0, ir[1:0], 1'b0}),
		.ptr_o     (ptr),
		.pair0_o   (pair0)
	);

	cfd_region u_dec (
		.addr_i   (d_addr),
		.region_o (d_region)
	);

	assign lpm_byte = (lpm_lock[1] == 1'b0) ? 8'h00 : (lpm_hi ? pm_data_i[15:8] : pm_data_i[7:0]);

	always_comb begin
		rf_we     = 1'b0;
		rf_waddr  = ra_addr;
		rf_wdata  = 8'h00;
		alu_op    = 1'b0;
		alu_res   = 9'h000;
		take_jump = 1'b0;
		jump_tgt  = rel_tgt;
		d_re      = 1'b0;
		d_we      = 1'b0;
		d_io      = 1'b0;
		d_addr    = {dext, ptr};
		if (state == ST_LDW) begin
			rf_we    = 1'b1;
			rf_waddr = ld_dst;
			rf_wdata = dm_rdata_i;
		end else if (state == ST_LPMW) begin
			rf_we    = 1'b1;
			rf_waddr = cfd_pkg::R_ZERO;
			rf_wdata = lpm_byte;
		end else if (exe) begin
			case (op)
				cfd_pkg::OP_ADD: begin
					alu_op  = 1'b1;
					alu_res = {1'b0, ra} + {1'b0, rb};
				end
				cfd_pkg::OP_SUB: begin
					alu_op  = 1'b1;
					alu_res = {1'b0, ra} - {1'b0, rb};
				end
				cfd_pkg::OP_AND: begin
					alu_op  = 1'b1;
					alu_res = {1'b0, ra & rb};
				end
				cfd_pkg::OP_SUBI: begin
					alu_op  = 1'b1;
					alu_res = {1'b0, ra} - {1'b0, kval};
				end
				cfd_pkg::OP_UNA: begin
					alu_op  = 1'b1;
					alu_res = ir[cfd_pkg::UNA_B] ? {1'b0, ra} - 9'h001 : {1'b0, ra} + 9'h001;
				end
				cfd_pkg::OP_LDI: begin
					rf_we    = 1'b1;
					rf_wdata = kval;
				end
				cfd_pkg::OP_IN, cfd_pkg::OP_OUT: begin
					d_re   = op == cfd_pkg::OP_IN;
					d_we   = op == cfd_pkg::OP_OUT;
					d_io   = 1'b1;
					d_addr = 24'(ir[cfd_pkg::IOA_HI:cfd_pkg::IOA_LO]);
				end
				cfd_pkg::OP_LD: d_re = 1'b1;
				cfd_pkg::OP_ST: d_we = 1'b1;
				cfd_pkg::OP_RJMP, cfd_pkg::OP_RCALL: take_jump = 1'b1;
				cfd_pkg::OP_RET: begin
					take_jump = 1'b1;
					jump_tgt  = rstk[rsp - 2'h1];
				end
				cfd_pkg::OP_BREQ: take_jump = flags_o[cfd_pkg::FL_Z];
				cfd_pkg::OP_MISC: begin
					if (sub == cfd_pkg::MS_IJMP) begin
						take_jump = 1'b1;
						jump_tgt  = z_word;
					end
				end
				default: begin
				end
			endcase
			if (alu_op) begin
				rf_we    = 1'b1;
				rf_wdata = alu_res[7:0];
			end
		end
	end

	// ****************************************
	// Fetch and program counter
	// ****************************************
	// Fetch only ever reads the program port
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			pc        <= cfd_pkg::PC_RESET;
			pm_addr_o <= cfd_pkg::PC_RESET;
			pm_rd_o   <= 1'b0;
			ir        <= 16'h0000;
			ir_pc     <= cfd_pkg::PC_RESET;
			ir_valid  <= 1'b0;
		end else begin
			pm_rd_o <= 1'b1;
			if (state == ST_LPMW) begin
				pm_addr_o <= pc;
			end else if (state == ST_EXEC && pm_rd_o) begin
				if (exe && take_jump) begin
					pc        <= jump_tgt;
					pm_addr_o <= jump_tgt;
					ir_valid  <= 1'b0;
				end else begin
					ir        <= pm_data_i;
					ir_pc     <= pc;
					ir_valid  <= 1'b1;
					pc        <= pc + 23'h00_0001;
					pm_addr_o <= (exe && op == cfd_pkg::OP_MISC && sub == cfd_pkg::MS_LPM)
						? z_word : pc + 23'h00_0001;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			state    <= ST_EXEC;
			ld_dst   <= 5'h00;
			lpm_hi   <= 1'b0;
			lpm_lock <= cfd_pkg::LOCK_NONE;
		end else begin
			case (state)
				ST_EXEC: begin
					if (d_re) begin
						state  <= ST_LDW;
						ld_dst <= d_io ? ir[cfd_pkg::IRD_HI:cfd_pkg::IRD_LO] : ra_addr;
					end else if (exe && op == cfd_pkg::OP_MISC && sub == cfd_pkg::MS_LPM) begin
						state    <= ST_LPMW;
						lpm_hi   <= dext[0];
						lpm_lock <= z_word >= cfd_pkg::BOOT_FIRST ? lock_boot_i
							: z_word >= cfd_pkg::TABLE_FIRST ? lock_tbl_i : lock_app_i;
					end
				end
				ST_LDW:  state <= ST_EXEC;
				ST_LPMW: state <= ST_EXEC;
				default: state <= ST_EXEC;
			endcase
		end
	end

	// ****************************************
	// Flags, extension bytes, return stack
	// ****************************************
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			flags_o <= 3'h0;
		end else if (alu_op) begin
			flags_o[cfd_pkg::FL_C] <= alu_res[8];
			flags_o[cfd_pkg::FL_Z] <= alu_res[7:0] == 8'h00;
			flags_o[cfd_pkg::FL_N] <= alu_res[7];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			dext <= 8'h00;
			pext <= 8'h00;
		end else if (exe && op == cfd_pkg::OP_MISC) begin
			if (sub == cfd_pkg::MS_SETX) begin
				dext <= kval;
			end
			if (sub == cfd_pkg::MS_SETP) begin
				pext <= kval;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			rsp <= 2'h0;
		end else if (exe && op == cfd_pkg::OP_RCALL) begin
			rstk[rsp] <= pc;
			rsp       <= rsp + 2'h1;
		end else if (exe && op == cfd_pkg::OP_RET) begin
			rsp <= rsp - 2'h1;
		end
	end

	// ****************************************
	// Data request outputs
	// ****************************************
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			dm_addr_o      <= 24'h00_0000;
			dm_re_o        <= 1'b0;
			dm_we_o        <= 1'b0;
			dm_wdata_o     <= 8'h00;
			dm_region_o    <= cfd_pkg::RG_IO;
			dm_io_direct_o <= 1'b0;
		end else begin
			dm_re_o        <= d_re;
			dm_we_o        <= d_we;
			dm_io_direct_o <= d_io;
			if (d_re || d_we) begin
				dm_addr_o   <= d_addr;
				dm_region_o <= d_region;
				dm_wdata_o  <= ra;
			end
		end
	end

	// ****************************************
	// Self-programming
	// ****************************************
	logic        spm_exe;
	logic [1:0]  spm_lock;
	assign spm_exe  = exe && op == cfd_pkg::OP_MISC && sub == cfd_pkg::MS_SPM;
	assign spm_lock = z_word >= cfd_pkg::BOOT_FIRST ? lock_boot_i
		: z_word >= cfd_pkg::TABLE_FIRST ? lock_tbl_i : lock_app_i;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			spm_req_o    <= 1'b0;
			spm_denied_o <= 1'b0;
			spm_addr_o   <= cfd_pkg::PC_RESET;
			spm_data_o   <= 16'h0000;
		end else begin
			spm_req_o    <= spm_exe && ir_pc >= cfd_pkg::BOOT_FIRST
				&& spm_lock == cfd_pkg::LOCK_NONE;
			spm_denied_o <= spm_exe && !(ir_pc >= cfd_pkg::BOOT_FIRST
				&& spm_lock == cfd_pkg::LOCK_NONE);
			if (spm_exe) begin
				spm_addr_o <= z_word;
				spm_data_o <= pair0;
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_FLUSH: assert property (exe && take_jump |=> !ir_valid && pc == $past(jump_tgt))
		else $error("prefetch not discarded on jump");
	AST_ADVANCE: assert property (exe && !take_jump && state == ST_EXEC |=> pc == $past(pc) + 23'h1)
		else $error("pc did not advance");
	AST_ONE_PER_CLK: assert property (exe && !take_jump && !d_re && !(op == cfd_pkg::OP_MISC && sub == cfd_pkg::MS_LPM) |=> exe)
		else $error("single-cycle op stalled");
	AST_LOAD_BOUND: assert property (state == ST_LDW |=> state == ST_EXEC)
		else $error("load wait too long");
	AST_FLAGS: assert property (alu_op |=> flags_o[cfd_pkg::FL_Z] == ($past(alu_res[7:0]) == 8'h00))
		else $error("zero flag wrong");
	AST_IO_REGION: assert property ((dm_re_o || dm_we_o) && dm_addr_o <= cfd_pkg::IO_LAST |-> dm_region_o == cfd_pkg::RG_IO)
		else $error("io region wrong");
	AST_DIRECT_IO: assert property (dm_io_direct_o |-> dm_addr_o <= cfd_pkg::DIO_LAST)
		else $error("direct io beyond 64");
	AST_EEP_REGION: assert property ((dm_re_o || dm_we_o) && dm_addr_o >= cfd_pkg::EEP_FIRST && dm_addr_o <= cfd_pkg::EEP_LAST |-> dm_region_o == cfd_pkg::RG_EEP)
		else $error("eeprom region wrong");
	AST_SRAM_BASE: assert property ((dm_re_o || dm_we_o) && dm_region_o == cfd_pkg::RG_SRAM |-> dm_addr_o >= cfd_pkg::SRAM_FIRST)
		else $error("sram below base");
	AST_SPM_BOOT: assert property (spm_req_o |-> $past(ir_pc) >= cfd_pkg::BOOT_FIRST && $past(spm_lock) == cfd_pkg::LOCK_NONE)
		else $error("spm outside boot or locked");
	AST_RESET_PC: assert property (@(posedge ref_clk_i) $rose(rst_n_i) |-> pm_addr_o == cfd_pkg::PC_RESET && !ir_valid)
		else $error("fetch not at zero after reset");

	COV_JUMP: cover property (exe && take_jump);
	COV_LOAD: cover property (state == ST_LDW);
	COV_SPM: cover property (spm_req_o);
	COV_LPM: cover property (state == ST_LPMW);

endmodule : cfd_core

//--- verilog/cfd_pkg.sv
// Constants for the fetch, execute and data space decode core.
// Assumes a single clock and a synchronous, active-low reset.
package cfd_pkg;

	// ****************************************
	// Widths and reset values
	// ****************************************
	localparam int          PC_W     = 23;
	localparam int          DA_W     = 24;
	localparam logic [22:0] PC_RESET = 23'h00_0000;
	localparam int          RSTK_N   = 4;

	// ****************************************
	// Instruction fields
	// ****************************************
	localparam int OP_HI  = 15;
	localparam int OP_LO  = 12;
	localparam int RD_HI  = 9;
	localparam int RD_LO  = 5;
	localparam int RR_HI  = 4;
	localparam int RR_LO  = 0;
	localparam int IRD_HI = 10;
	localparam int IRD_LO = 6;
	localparam int IOA_HI = 5;
	localparam int IOA_LO = 0;
	localparam int SUB_HI = 11;
	localparam int SUB_LO = 8;
	localparam int K_HI   = 7;
	localparam int K_LO   = 0;
	localparam int OFS_HI = 11;
	localparam int OFS_LO = 0;
	localparam int PS_HI  = 1;
	localparam int PS_LO  = 0;
	localparam int UNA_B  = 0;

	// ****************************************
	// Opcodes
	// ****************************************
	localparam logic [3:0] OP_NOP   = 4'h0;
	localparam logic [3:0] OP_ADD   = 4'h1;
	localparam logic [3:0] OP_SUB   = 4'h2;
	localparam logic [3:0] OP_AND   = 4'h3;
	localparam logic [3:0] OP_LDI   = 4'h4;
	localparam logic [3:0] OP_SUBI  = 4'h5;
	localparam logic [3:0] OP_UNA   = 4'h6;
	localparam logic [3:0] OP_IN    = 4'h7;
	localparam logic [3:0] OP_OUT   = 4'h8;
	localparam logic [3:0] OP_LD    = 4'h9;
	localparam logic [3:0] OP_ST    = 4'hA;
	localparam logic [3:0] OP_RJMP  = 4'hB;
	localparam logic [3:0] OP_RCALL = 4'hC;
	localparam logic [3:0] OP_RET   = 4'hD;
	localparam logic [3:0] OP_MISC  = 4'hE;
	localparam logic [3:0] OP_BREQ  = 4'hF;
	localparam logic [3:0] MS_SETX  = 4'h0;
	localparam logic [3:0] MS_SETP  = 4'h1;
	localparam logic [3:0] MS_IJMP  = 4'h2;
	localparam logic [3:0] MS_SPM   = 4'h3;
	localparam logic [3:0] MS_LPM   = 4'h4;
	localparam logic [4:0] LDI_BASE = 5'h10;
	localparam logic [4:0] R_ZERO   = 5'h00;

	// ****************************************
	// Data space map, region codes
	// ****************************************
	localparam logic [23:0] IO_LAST    = 24'h00_0FFF;
	localparam logic [23:0] DIO_LAST   = 24'h00_003F;
	localparam logic [23:0] EEP_FIRST  = 24'h00_1000;
	localparam logic [23:0] EEP_LAST   = 24'h00_1FFF;
	localparam logic [23:0] SRAM_FIRST = 24'h00_2000;
	localparam logic [23:0] SRAM_LAST  = 24'h00_5FFF;
	localparam logic [3:0]  RG_IO      = 4'h1;
	localparam logic [3:0]  RG_EEP     = 4'h2;
	localparam logic [3:0]  RG_SRAM    = 4'h4;
	localparam logic [3:0]  RG_EXT     = 4'h8;

	// ****************************************
	// Program memory sections and lock codes
	// ****************************************
	localparam logic [22:0] TABLE_FIRST = 23'h01_8000;
	localparam logic [22:0] BOOT_FIRST  = 23'h02_0000;
	localparam logic [1:0]  LOCK_NONE   = 2'h3;
	localparam logic [1:0]  LOCK_WR     = 2'h2;

	// ****************************************
	// Flag positions
	// ****************************************
	localparam int FL_C = 0;
	localparam int FL_Z = 1;
	localparam int FL_N = 2;

endpackage : cfd_pkg

//--- verilog/cfd_regfile.sv
// Working register file: 32 x 8 bits, two operand ports, one write port.
// Assumes writes and reads on the same clock; reads are combinational.
module cfd_regfile (
	// Clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       rst_n_i,
	// Write port
	input  wire logic       we_i,
	input  wire logic [4:0] waddr_i,
	input  wire logic [7:0] wdata_i,
	// Operand ports
	input  wire logic [4:0] ra_addr_i,
	input  wire logic [4:0] rb_addr_i,
	output logic      [7:0] ra_o,
	output logic      [7:0] rb_o,
	// Pointer pairs
	input  wire logic [4:0] ptr_lo_i,
	output logic      [15:0] ptr_o,
	output logic      [15:0] pair0_o
);
	logic [7:0] regs [32];

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < 32; i++) begin
				regs[i] <= 8'h00;
			end
		end else if (we_i) begin
			regs[waddr_i] <= wdata_i;
		end
	end

	// Pairs: low byte at even index, high byte one above
	assign ra_o    = regs[ra_addr_i];
	assign rb_o    = regs[rb_addr_i];
	assign ptr_o   = {regs[ptr_lo_i + 5'h01], regs[ptr_lo_i]};
	assign pair0_o = {regs[5'h01], regs[5'h00]};

endmodule : cfd_regfile

//--- verilog/cfd_region.sv
// Data space address decoder: one-hot region of a 24-bit data address.
// Assumes the address is stable when it is sampled.
module cfd_region (
	// Address in, region out
	input  wire logic [23:0] addr_i,
	output logic      [3:0]  region_o
);
	always_comb begin
		if (addr_i <= cfd_pkg::IO_LAST) begin
			region_o = cfd_pkg::RG_IO;
		end else if (addr_i >= cfd_pkg::EEP_FIRST && addr_i <= cfd_pkg::EEP_LAST) begin
			region_o = cfd_pkg::RG_EEP;
		end else if (addr_i >= cfd_pkg::SRAM_FIRST && addr_i <= cfd_pkg::SRAM_LAST) begin
			region_o = cfd_pkg::RG_SRAM;
		end else begin
			region_o = cfd_pkg::RG_EXT;
		end
	end

endmodule : cfd_region

//--- verification/cfd_mem_model.sv
// Behavioural program and data memory facing the core.
// Assumes the bench loads pmem and dmem before it releases the core from reset.
module cfd_mem_model (
	// Clock
	input  wire logic        ref_clk_i,
	// Program side
	input  wire logic [22:0] pm_addr_i,
	input  wire logic        pm_rd_i,
	output logic      [15:0] pm_data_o,
	// Data side
	input  wire logic [23:0] dm_addr_i,
	input  wire logic        dm_re_i,
	input  wire logic        dm_we_i,
	input  wire logic [7:0]  dm_wdata_i,
	input  wire logic [3:0]  dm_region_i,
	input  wire logic        dm_io_direct_i,
	input  wire logic [2:0]  flags_i,
	output logic      [7:0]  dm_rdata_o,
	// Self-programming
	input  wire logic        spm_req_i,
	input  wire logic        spm_denied_i,
	input  wire logic [22:0] spm_addr_i
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] pmem [512];
	logic [7:0]  dmem [256];
	logic [15:0] pm_last = 16'h0000;
	logic [7:0]  dm_last = 8'h00;
	logic [39:0] wlog [$];
	int          n_ok;
	int          n_no;
	logic [22:0] spm_last;

	// ****************************************
	// Answers; idle lines show the inverse of the last value
	// ****************************************
	always_comb begin
		pm_data_o  = pm_rd_i ? pmem[{pm_addr_i[17], pm_addr_i[7:0]}] : ~pm_last;
		dm_rdata_o = dm_re_i ? dmem[dm_addr_i[7:0]] : ~dm_last;
	end

	always @(posedge ref_clk_i) begin
		if (pm_rd_i)
			pm_last <= pm_data_o;
		if (dm_re_i)
			dm_last <= dm_rdata_o;
		if (dm_we_i)
			wlog.push_back({dm_io_direct_i, flags_i, dm_region_i, dm_addr_i, dm_wdata_i});
		if (spm_req_i) begin
			n_ok     <= n_ok + 1;
			spm_last <= spm_addr_i;
		end
		if (spm_denied_i)
			n_no <= n_no + 1;
	end

endmodule : cfd_mem_model

//--- verification/test_cfd_core.sv
// Self-checking bench for the core, one task per scenario.
// Assumes the memory model answers both ports combinationally.
module test_cfd_core;
	timeunit 1ns;
	timeprecision 1ps;

	logic        ref_clk, rst_n, pm_rd, dm_re, dm_we, dm_io, spm_req, spm_no;
	logic [1:0]  lock_app, lock_tbl, lock_boot;
	logic [22:0] pm_addr, spm_addr, pa;
	logic [15:0] pm_data, spm_data;
	logic [23:0] dm_addr;
	logic [7:0]  dm_wdata, dm_rdata;
	logic [3:0]  dm_region;
	logic [2:0]  flags;
	logic [39:0] e;
	int          errors;
	int          n_compared;

	cfd_core u_cfd_core (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .pm_addr_o(pm_addr),
		.pm_rd_o(pm_rd), .pm_data_i(pm_data), .dm_addr_o(dm_addr), .dm_re_o(dm_re),
		.dm_we_o(dm_we), .dm_wdata_o(dm_wdata), .dm_region_o(dm_region),
		.dm_io_direct_o(dm_io), .dm_rdata_i(dm_rdata), .spm_req_o(spm_req),
		.spm_denied_o(spm_no), .spm_addr_o(spm_addr), .spm_data_o(spm_data),
		.lock_app_i(lock_app), .lock_tbl_i(lock_tbl), .lock_boot_i(lock_boot),
		.flags_o(flags));

	cfd_mem_model u_cfd_mem_model (.ref_clk_i(ref_clk), .pm_addr_i(pm_addr),
		.pm_rd_i(pm_rd), .pm_data_o(pm_data), .dm_addr_i(dm_addr), .dm_re_i(dm_re),
		.dm_we_i(dm_we), .dm_wdata_i(dm_wdata), .dm_region_i(dm_region),
		.dm_io_direct_i(dm_io), .flags_i(flags), .dm_rdata_o(dm_rdata),
		.spm_req_i(spm_req), .spm_denied_i(spm_no), .spm_addr_i(spm_addr));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [15:0] f_k(input logic [3:0] op, input logic [3:0] n,
		input logic [7:0] k);
		return {op, n, k};
	endfunction : f_k

	function automatic logic [15:0] f_rr(input logic [3:0] op, input logic [4:0] d,
		input logic [4:0] r);
		return {op, 2'h0, d, r};
	endfunction : f_rr

	function automatic logic [39:0] ent(input int i);
		return u_cfd_mem_model.wlog[i];
	endfunction : ent

	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic emit(input logic [15:0] w);
		u_cfd_mem_model.pmem[{pa[17], pa[7:0]}] = w;
		pa++;
	endtask : emit

	task automatic fresh;
		for (int i = 0; i < 512; i++)
			u_cfd_mem_model.pmem[i] = 16'h0000;
		pa = 23'h000000;
	endtask : fresh

	task automatic hold_reset(input int n);
		@(posedge ref_clk) #2;
		rst_n = 1'b0;
		u_cfd_mem_model.wlog.delete();
		u_cfd_mem_model.n_ok = 0;
		u_cfd_mem_model.n_no = 0;
		repeat (n) @(posedge ref_clk);
		#2 rst_n = 1'b1;
	endtask : hold_reset

	task automatic run(input int n);
		hold_reset(n);
		repeat (80) @(posedge ref_clk);
		#2;
	endtask : run

	task automatic end_of_test;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset_fetch;
		fresh();
		hold_reset(20);
		@(posedge ref_clk) #2;
		check(pm_rd, 1'b1);
		for (int k = 0; k < 6; k++) begin
			check(pm_addr, 23'(k));
			@(posedge ref_clk) #2;
		end
	endtask : t_reset_fetch

	task automatic t_alu;
		logic [7:0] d[4] = '{8'hFE, 8'h03, 8'h00, 8'h01};
		logic [2:0] f[3] = '{3'h5, 3'h1, 3'h2};
		fresh();
		emit(f_k(cfd_pkg::OP_LDI, 4'h0, 8'h03));
		emit(f_k(cfd_pkg::OP_LDI, 4'h1, 8'h05));
		emit(f_k(cfd_pkg::OP_LDI, 4'hB, 8'h20));
		emit(f_k(cfd_pkg::OP_LDI, 4'hA, 8'h00));
		emit(f_rr(cfd_pkg::OP_SUB, 5'h10, 5'h11));
		emit(f_rr(cfd_pkg::OP_ST, 5'h10, 5'h00));
		emit(f_rr(cfd_pkg::OP_ADD, 5'h10, 5'h11));
		emit(f_rr(cfd_pkg::OP_ST, 5'h10, 5'h00));
		emit(f_k(cfd_pkg::OP_SUBI, 4'h0, 8'h03));
		emit(f_rr(cfd_pkg::OP_ST, 5'h10, 5'h00));
		emit(f_rr(cfd_pkg::OP_UNA, 5'h10, 5'h00));
		emit(f_rr(cfd_pkg::OP_ST, 5'h10, 5'h00));
		emit(f_k(cfd_pkg::OP_RJMP, 4'hF, 8'hFF));
		run(2);
		check(u_cfd_mem_model.wlog.size(), 4);
		for (int i = 0; i < 4; i++) begin
			e = ent(i);
			check(e[35:0], {4'h4, 24'h002000, d[i]});
			if (i < 3)
				check(e[38:36], f[i]);
		end
	endtask : t_alu

	task automatic t_region;
		logic [23:0] a[9] = '{24'h00003F, 24'h000040, 24'h000FFF, 24'h001000,
			24'h001FFF, 24'h002000, 24'h005FFF, 24'h006000, 24'h123456};
		logic [3:0] r[9] = '{4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h4, 4'h4, 4'h8, 4'h8};
		fresh();
		emit(f_k(cfd_pkg::OP_LDI, 4'h0, 8'h77));
		foreach (a[i]) begin
			emit(f_k(cfd_pkg::OP_MISC, cfd_pkg::MS_SETX, a[i][23:16]));
			emit(f_k(cfd_pkg::OP_LDI, 4'hB, a[i][15:8]));
			emit(f_k(cfd_pkg::OP_LDI, 4'hA, a[i][7:0]));
			emit(f_rr(cfd_pkg::OP_ST, 5'h10, 5'h00));
		end
		emit({cfd_pkg::OP_OUT, 1'b0, 5'h10, 6'h3F});
		emit(f_k(cfd_pkg::OP_RJMP, 4'hF, 8'hFF));
		run(2);
		foreach (a[i]) begin
			e = ent(i);
			check({e[39], e[35:0]}, {1'b0, r[i], a[i], 8'h77});
		end
		e = ent(9);
		check({e[39], e[35:0]}, {1'b1, 4'h1, 24'h00003F, 8'h77});
	endtask : t_region

	task automatic t_load;
		fresh();
		u_cfd_mem_model.dmem[8'h10] = 8'h5A;
		u_cfd_mem_model.dmem[8'h00] = 8'hC3;
		emit({cfd_pkg::OP_IN, 1'b0, 5'h12, 6'h10});
		emit(f_k(cfd_pkg::OP_LDI, 4'hB, 8'h10));
		emit(f_k(cfd_pkg::OP_LDI, 4'hA, 8'h00));
		emit(f_rr(cfd_pkg::OP_LD, 5'h13, 5'h00));
		emit(f_k(cfd_pkg::OP_LDI, 4'hB, 8'h20));
		emit(f_rr(cfd_pkg::OP_ST, 5'h12, 5'h00));
		emit(f_rr(cfd_pkg::OP_ST, 5'h13, 5'h00));
		emit(f_k(cfd_pkg::OP_RJMP, 4'hF, 8'hFF));
		run(2);
		e = ent(0);
		check(e[7:0], 8'h5A);
		e = ent(1);
		check(e[7:0], 8'hC3);
	endtask : t_load

	task automatic t_jump;
		fresh();
		emit(f_k(cfd_pkg::OP_LDI, 4'h0, 8'h11));
		emit(f_k(cfd_pkg::OP_LDI, 4'hB, 8'h20));
		emit(f_k(cfd_pkg::OP_LDI, 4'hA, 8'h00));
		emit(f_k(cfd_pkg::OP_RJMP, 4'h0, 8'h01));
		emit(f_k(cfd_pkg::OP_LDI, 4'h0, 8'h99));
		emit(f_rr(cfd_pkg::OP_ST, 5'h10, 5'h00));
		emit(f_k(cfd_pkg::OP_RJMP, 4'hF, 8'hFF));
		run(2);
		check(u_cfd_mem_model.wlog.size(), 1);
		e = ent(0);
		check(e[7:0], 8'h11);
	endtask : t_jump

	task automatic t_flow;
		for (int k = 0; k < 2; k++) begin
			fresh();
			emit(f_k(cfd_pkg::OP_LDI, 4'h0, 8'h0F));
			emit(f_k(cfd_pkg::OP_LDI, 4'h1, 8'h3C));
			emit(f_k(cfd_pkg::OP_LDI, 4'hB, 8'h20));
			emit(f_rr(cfd_pkg::OP_AND, 5'h10, 5'h11));
			emit(f_k(cfd_pkg::OP_BREQ, 4'h0, 8'h01));
			emit(f_k(cfd_pkg::OP_RCALL, 4'h0, 8'h07));
			emit(f_k(cfd_pkg::OP_BREQ, 4'h0, 8'h01));
			emit(f_k(cfd_pkg::OP_LDI, 4'h0, 8'h99));
			emit(f_rr(cfd_pkg::OP_ST, 5'h10, 5'h00));
			emit(f_k(cfd_pkg::OP_LDI, 4'hE, 8'h01));
			emit(f_k(cfd_pkg::OP_MISC, cfd_pkg::MS_LPM, 8'h00));
			emit(f_rr(cfd_pkg::OP_ST, 5'h00, 5'h00));
			emit(f_k(cfd_pkg::OP_RJMP, 4'hF, 8'hFF));
			emit(f_k(cfd_pkg::OP_SUBI, 4'h0, 8'h0C));
			emit(f_k(cfd_pkg::OP_RET, 4'h0, 8'h00));
			lock_app = k ? 2'h1 : 2'h3;
			run(2);
			check(u_cfd_mem_model.wlog.size(), 2);
			e = ent(0);
			check(e[38:0], {3'h2, 4'h4, 24'h002000, 8'h00});
			e = ent(1);
			check(e[7:0], k ? 8'h00 : 8'h3C);
		end
	endtask : t_flow

	task automatic t_spm;
		logic [1:0] la[3] = '{2'h3, 2'h0, 2'h3};
		logic [1:0] lt[3] = '{2'h3, 2'h3, 2'h2};
		int         ok[3] = '{2, 1, 1};
		u_cfd_mem_model.dmem[8'h21] = 8'hA5;
		for (int k = 0; k < 3; k++) begin
			fresh();
			emit({cfd_pkg::OP_IN, 1'b0, 5'h01, 6'h21});
			emit(f_k(cfd_pkg::OP_MISC, cfd_pkg::MS_SPM, 8'h00));
			emit(f_k(cfd_pkg::OP_MISC, cfd_pkg::MS_SETP, 8'h02));
			emit(f_k(cfd_pkg::OP_LDI, 4'hE, 8'h00));
			emit(f_k(cfd_pkg::OP_LDI, 4'hF, 8'h00));
			emit(f_k(cfd_pkg::OP_MISC, cfd_pkg::MS_IJMP, 8'h00));
			pa = cfd_pkg::BOOT_FIRST;
			emit(f_k(cfd_pkg::OP_MISC, cfd_pkg::MS_SETP, 8'h00));
			emit(f_k(cfd_pkg::OP_MISC, cfd_pkg::MS_SPM, 8'h00));
			emit(f_k(cfd_pkg::OP_MISC, cfd_pkg::MS_SETP, 8'h01));
			emit(f_k(cfd_pkg::OP_LDI, 4'hF, 8'h80));
			emit(f_k(cfd_pkg::OP_MISC, cfd_pkg::MS_SPM, 8'h00));
			emit(f_k(cfd_pkg::OP_RJMP, 4'hF, 8'hFF));
			lock_app = la[k];
			lock_tbl = lt[k];
			run(2);
			check(u_cfd_mem_model.n_ok, ok[k]);
			check(u_cfd_mem_model.n_no, 3 - ok[k]);
			check(spm_data, 16'hA500);
			if (k == 0)
				check(u_cfd_mem_model.spm_last, 23'h018000);
		end
	endtask : t_spm

	// ****************************************
	// Clock, sequence and watchdog
	// ****************************************
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	initial begin
		rst_n = 1'b0;
		lock_app = 2'h3;
		lock_tbl = 2'h3;
		lock_boot = 2'h3;
		pa = 23'h000000;
		errors = 0;
		n_compared = 0;
		t_reset_fetch();
		t_alu();
		t_region();
		t_load();
		t_jump();
		t_flow();
		t_spm();
		end_of_test();
	end

	initial begin
		#500us;
		errors++;
		end_of_test();
	end

endmodule : test_cfd_core
